// [inc/csv_pkg.sv]
// shared constants for the cable signal variance control block
// assumes a 32-bit AXI4-Lite slave and one 100 MHz clock
`default_nettype none
package csv_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] CTRL_IDX = 8'h1a;
	localparam logic [7:0] DATA_IDX = 8'h1b;

	// control register fields
	localparam int RDY_BIT = 15;
	localparam int FRZ_BIT = 3;
	localparam int PER_LO = 1;
	localparam int EN_BIT = 0;

	// reset values
	localparam logic EN_RST = 1'b0;
	localparam logic FRZ_RST = 1'b0;
	localparam logic RDY_RST = 1'b0;
	localparam logic [1:0] PER_RST = 2'h0;
	localparam logic [31:0] DATA_RST = 32'h0;

	// one period unit in receive-clock cycles
	localparam int UNIT_CYCLES_DEF = 131072;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef logic [7:0] csv_addr_t;

	function automatic csv_addr_t csv_byte_addr(input logic [7:0] idx);
		csv_byte_addr = 8'(idx << 2);
	endfunction

endpackage
`default_nettype wire

// [inc/csv_link_if.sv]
// link between register side and the accumulator
// assumes both ends run on the same clock
`timescale 1ns/10ps
`default_nettype none
interface csv_link_if;
	logic en;
	logic restart;
	logic [1:0] per;
	logic done;
	logic [31:0] result;

	modport ctl
	(
		output en,
		output restart,
		output per,
		input done,
		input result
	);

	modport acc
	(
		input en,
		input restart,
		input per,
		output done,
		output result
	);
endinterface
`default_nettype wire

// [verilog/csv_accum.sv]
// variance accumulator and computation period timer
// assumes signed receive samples centred on zero, synchronous to CLK
`timescale 1ns/10ps
`default_nettype none
module csv_accum
#(
	parameter int UNIT_CYCLES = csv_pkg::UNIT_CYCLES_DEF
)
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// receive samples
	input wire logic signed [7:0] sample,
	input wire logic sample_valid,
	// control side
	csv_link_if.acc lnk
);
	import csv_pkg::*;

	logic [17:0] cyc;
	logic [2:0] units;
	logic [31:0] sum;
	logic done;
	logic [31:0] result;
	logic [17:0] next_cyc;
	logic [2:0] next_units;
	logic [31:0] next_sum;
	logic next_done;
	logic [31:0] next_result;
	logic [31:0] sq;
	logic [2:0] last_unit;
	logic signed [15:0] smp_wide;

	assign lnk.done = done;
	assign lnk.result = result;

	always_comb
	begin
		// widen before squaring so the product keeps all 16 bits
		smp_wide = 16'(sample);
		sq = sample_valid ? {16'h0, smp_wide * smp_wide} : 32'h0;
		// period is 2*(per+1) units, last unit index 2*per+1
		last_unit = {lnk.per, 1'b1};
		next_cyc = cyc;
		next_units = units;
		next_sum = sum + sq;
		next_done = 1'b0;
		next_result = result;
		if (!lnk.en || lnk.restart)
		begin
			next_cyc = 18'h0;
			next_units = 3'h0;
			next_sum = 32'h0;
		end
		else if (cyc == 18'(UNIT_CYCLES - 1))
		begin
			next_cyc = 18'h0;
			if (units == last_unit)
			begin
				next_units = 3'h0;
				next_done = 1'b1;
				next_result = sum + sq;
				next_sum = 32'h0;
			end
			else
			begin
				next_units = units + 3'h1;
			end
		end
		else
		begin
			next_cyc = cyc + 18'h1;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cyc <= 18'h0;
			units <= 3'h0;
			sum <= 32'h0;
			done <= 1'b0;
			result <= 32'h0;
		end
		else
		begin
			cyc <= next_cyc;
			units <= next_units;
			sum <= next_sum;
			done <= next_done;
			result <= next_result;
		end
	end
endmodule
`default_nettype wire

// [verilog/csv_top.sv]
// cable signal variance control: registers over AXI4-Lite and the accumulator
// assumes one 100 MHz clock, receive samples synchronous to it
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module csv_top
#(
	parameter int UNIT_CYCLES = csv_pkg::UNIT_CYCLES_DEF
)
(
	// clock and reset
	input wire logic CLK,
	input wire logic ARST_N,
	// receive samples
	input wire logic signed [7:0] RX_SAMPLE,
	input wire logic RX_SAMPLE_VALID,
	// axi4-lite write address and data
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire csv_pkg::csv_addr_t S_AXI_AWADDR,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	// axi4-lite write response
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	output logic [1:0] S_AXI_BRESP,
	// axi4-lite read
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	input wire csv_pkg::csv_addr_t S_AXI_ARADDR,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP
);
	import csv_pkg::*;

	csv_link_if lnk();

	csv_accum #(.UNIT_CYCLES(UNIT_CYCLES)) csv_accum_inst
	(
		.clk(CLK),
		.arst_n(ARST_N),
		.sample(RX_SAMPLE),
		.sample_valid(RX_SAMPLE_VALID),
		.lnk(lnk)
	);

	////////////////////////////////////////////////////////////////////////
	// bus channel state

	logic awready;
	logic wready;
	logic bvalid;
	logic [1:0] bresp;
	logic arready;
	logic rvalid;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic next_awready;
	logic next_wready;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic next_arready;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	// register state
	logic en;
	logic [1:0] per;
	logic frz;
	logic rdy;
	logic [31:0] data;
	logic half;
	logic restart;
	logic next_en;
	logic [1:0] next_per;
	logic next_frz;
	logic next_rdy;
	logic [31:0] next_data;
	logic next_half;
	logic next_restart;

	logic wr_fire;
	logic rd_fire;
	logic ctrl_wr;
	logic ctrl_hit_w;
	logic data_hit_w;
	logic ctrl_hit_r;
	logic data_hit_r;
	logic pair_done;
	logic [15:0] ctrl_val;

	assign lnk.en = en;
	assign lnk.per = per;
	assign lnk.restart = restart;

	assign S_AXI_AWREADY = awready;
	assign S_AXI_WREADY = wready;
	assign S_AXI_BVALID = bvalid;
	assign S_AXI_BRESP = bresp;
	assign S_AXI_ARREADY = arready;
	assign S_AXI_RVALID = rvalid;
	assign S_AXI_RDATA = rdata;
	assign S_AXI_RRESP = rresp;

	////////////////////////////////////////////////////////////////////////
	// bus handshakes and register reads

	always_comb
	begin
		// address and data are both held by the master until this edge
		wr_fire = awready;
		rd_fire = arready;
		ctrl_hit_w = S_AXI_AWADDR == csv_byte_addr(CTRL_IDX);
		data_hit_w = S_AXI_AWADDR == csv_byte_addr(DATA_IDX);
		ctrl_hit_r = S_AXI_ARADDR == csv_byte_addr(CTRL_IDX);
		data_hit_r = S_AXI_ARADDR == csv_byte_addr(DATA_IDX);
		ctrl_val = 16'h0;
		ctrl_val[RDY_BIT] = rdy;
		ctrl_val[FRZ_BIT] = frz;
		ctrl_val[PER_LO +: 2] = per;
		ctrl_val[EN_BIT] = en;

		// both channels taken together once, only with no response pending
		next_awready = S_AXI_AWVALID && S_AXI_WVALID && !awready && !bvalid;
		next_wready = next_awready;
		next_bvalid = bvalid;
		next_bresp = bresp;
		if (bvalid && S_AXI_BREADY)
		begin
			next_bvalid = 1'b0;
		end
		if (wr_fire)
		begin
			next_bvalid = 1'b1;
			next_bresp = (ctrl_hit_w || data_hit_w) ? RESP_OKAY : RESP_SLVERR;
		end

		next_arready = S_AXI_ARVALID && !arready && !rvalid;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (rvalid && S_AXI_RREADY)
		begin
			next_rvalid = 1'b0;
		end
		if (rd_fire)
		begin
			next_rvalid = 1'b1;
			next_rresp = RESP_OKAY;
			if (ctrl_hit_r)
			begin
				next_rdata = {16'h0, ctrl_val};
			end
			else if (data_hit_r)
			begin
				next_rdata = {16'h0, half ? data[31:16] : data[15:0]};
			end
			else
			begin
				next_rdata = 32'h0;
				next_rresp = RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= RESP_OKAY;
		end
		else
		begin
			awready <= next_awready;
			wready <= next_wready;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			arready <= next_arready;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control register, result loading and read pairing

	always_comb
	begin
		ctrl_wr = wr_fire && ctrl_hit_w && S_AXI_WSTRB[0];
		// any other read breaks the pair; data register writes are ignored
		pair_done = rd_fire && data_hit_r && half;
		next_half = half;
		if (rd_fire)
		begin
			next_half = data_hit_r ? !half : 1'b0;
		end
		next_en = en;
		next_per = per;
		next_frz = frz;
		next_restart = 1'b0;
		if (pair_done)
		begin
			next_frz = 1'b0;
		end
		if (ctrl_wr)
		begin
			next_en = S_AXI_WDATA[EN_BIT];
			next_per = S_AXI_WDATA[PER_LO +: 2];
			next_restart = S_AXI_WDATA[PER_LO +: 2] != per;
			next_frz = S_AXI_WDATA[FRZ_BIT];
			// a fresh hold starts a new low-then-high pair
			if (S_AXI_WDATA[FRZ_BIT] && !frz)
			begin
				next_half = 1'b0;
			end
		end
		next_data = data;
		next_rdy = rdy;
		if (pair_done)
		begin
			next_rdy = 1'b0;
		end
		// a load wins over a clear arriving in the same cycle
		if (lnk.done && !frz)
		begin
			next_data = lnk.result;
			next_rdy = 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			en <= EN_RST;
			per <= PER_RST;
			frz <= FRZ_RST;
			rdy <= RDY_RST;
			data <= DATA_RST;
			half <= 1'b0;
			restart <= 1'b0;
		end
		else
		begin
			en <= next_en;
			per <= next_per;
			frz <= next_frz;
			rdy <= next_rdy;
			data <= next_data;
			half <= next_half;
			restart <= next_restart;
		end
	end
endmodule
`default_nettype wire

// [sim/csv_monitor.sv]
// handshake and read-data checks on the csv_top register port
// assumes it is bound to csv_top and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module csv_monitor
(
	// clock and reset
	input wire logic CLK,
	input wire logic ARST_N,
	// axi4-lite
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_ARVALID,
	input wire csv_pkg::csv_addr_t S_AXI_ARADDR,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [31:0] S_AXI_RDATA
);
	import csv_pkg::*;
	logic ctl_rd;
	logic next_ctl_rd;
	// address is only trustworthy in the handshake cycle
	always_comb next_ctl_rd = S_AXI_ARREADY ? (S_AXI_ARADDR == 8'(CTRL_IDX << 2)) : ctl_rd;
	always_ff @(posedge CLK or negedge ARST_N)
		if (!ARST_N)
			ctl_rd <= 1'b0;
		else
			ctl_rd <= next_ctl_rd;
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	wr_take_a: assert property (S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_AWREADY && !S_AXI_BVALID |=> S_AXI_AWREADY)
		else $error("write not taken");
	aw_pair_a: assert property (S_AXI_AWREADY == S_AXI_WREADY) else $error("aw and w ready differ");
	b_after_a: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY && S_AXI_BVALID) else $error("no write response");
	b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped");
	rd_take_a: assert property (S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID |=> S_AXI_ARREADY)
		else $error("read not taken");
	r_after_a: assert property (S_AXI_ARREADY |=> !S_AXI_ARREADY && S_AXI_RVALID) else $error("no read data");
	r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped");
	r_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0) else $error("upper half set");
	rsvd_zero_a: assert property (S_AXI_RVALID && ctl_rd |-> S_AXI_RDATA[14:4] == 11'h0) else $error("reserved set");
	cover property (S_AXI_BVALID && S_AXI_BREADY);
	cover property (S_AXI_RVALID && ctl_rd && S_AXI_RDATA[15]);
	cover property (S_AXI_RVALID && ctl_rd && S_AXI_RDATA[3]);
endmodule
bind csv_top csv_monitor csv_monitor_inst (.CLK, .ARST_N, .S_AXI_AWVALID, .S_AXI_WVALID, .S_AXI_AWREADY,
	.S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP, .S_AXI_ARVALID, .S_AXI_ARADDR, .S_AXI_ARREADY,
	.S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA);
`default_nettype wire

// [sim/csv_top_bench.sv]
// self-checking bench for csv_top through its register port
// assumes csv_pkg is compiled first and csv_monitor is bound to csv_top
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; $display("unexpected %0t mismatch got %h want %h", $time, a, b); end end
module csv_top_bench;
	import csv_pkg::*;
	// short unit keeps periods at 128..512 cycles
	localparam int UNIT = 64;
	localparam logic [7:0] CA = 8'(CTRL_IDX << 2);
	localparam logic [7:0] DA = 8'(DATA_IDX << 2);
	localparam logic [31:0] SUM0 = 32'(127 * 127 * 2 * UNIT);
	localparam logic [31:0] SUM3 = 32'(2 * 4 * UNIT);
	logic clk, arst_n, smp_v, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
	logic signed [7:0] smp;
	logic [7:0] awa, ara;
	logic [31:0] wd, rdat, d;
	logic [1:0] bresp, rresp, rs;
	logic [3:0] ws;
	int error_cnt, checks_done, cyc;
	csv_top #(.UNIT_CYCLES(UNIT)) csv_top_inst (.CLK(clk), .ARST_N(arst_n), .RX_SAMPLE(smp), .RX_SAMPLE_VALID(smp_v),
		.S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_BRESP(bresp),
		.S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
		.S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp));
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
		@(posedge clk);
		awv <= 1'b1;
		wv <= 1'b1;
		awa <= a;
		wd <= v;
		do @(posedge clk); while (!awr);
		awv <= 1'b0;
		wv <= 1'b0;
		do @(posedge clk); while (!bv);
		br <= 1'b1;
		@(posedge clk);
		br <= 1'b0;
		`CHK(bresp, e)
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		do @(posedge clk); while (!arr);
		arv <= 1'b0;
		do @(posedge clk); while (!rv);
		rr <= 1'b1;
		@(posedge clk);
		rr <= 1'b0;
		d = rdat;
		rs = rresp;
	endtask
	task automatic wait_rdy();
		do rd(CA); while (!d[RDY_BIT]);
	endtask
	task automatic t_reset();
		rd(CA);
		`CHK(d, 32'h0)
		`CHK(rs, RESP_OKAY)
		rd(DA);
		`CHK(d, DATA_RST)
		$display("test reset done");
	endtask
	task automatic t_map();
		wr(CA, 32'hfff0, RESP_OKAY);
		rd(CA);
		`CHK(d, 32'h0)
		// a write with its low byte lane off must leave enable clear
		ws <= 4'h0;
		wr(CA, 32'h1, RESP_OKAY);
		ws <= 4'hf;
		rd(CA);
		`CHK(d, 32'h0)
		wr(8'h00, 32'h1, RESP_SLVERR);
		rd(8'h00);
		`CHK(rs, RESP_SLVERR)
		$display("test map done");
	endtask
	task automatic t_load();
		wr(CA, 32'h1, RESP_OKAY);
		wait_rdy();
		rd(DA);
		rd(DA);
		rd(CA);
		`CHK(d[RDY_BIT], 1'b0)
		wait_rdy();
		wr(CA, 32'h9, RESP_OKAY);
		rd(DA);
		`CHK(d, {16'h0, SUM0[15:0]})
		rd(DA);
		`CHK(d, {16'h0, SUM0[31:16]})
		rd(CA);
		`CHK(d[FRZ_BIT], 1'b0)
		$display("test load done");
	endtask
	task automatic t_hold();
		smp <= 8'sh01;
		wr(CA, 32'h9, RESP_OKAY);
		repeat (300) @(posedge clk);
		rd(CA);
		`CHK(d, 32'h9)
		rd(DA);
		`CHK(d, {16'h0, SUM0[15:0]})
		rd(DA);
		`CHK(d, {16'h0, SUM0[31:16]})
		rd(CA);
		`CHK(d[FRZ_BIT], 1'b0)
		$display("test hold done");
	endtask
	task automatic t_per();
		logic [31:0] exp_sum;
		// period selects 1 to 3 in turn; the first result after each change shows the restart
		for (int s = 1; s <= 3; s++)
		begin
			exp_sum = 32'(2 * (s + 1) * UNIT);
			wr(CA, 32'(2 * s + 1), RESP_OKAY);
			rd(DA);
			rd(DA);
			wait_rdy();
			rd(DA);
			`CHK(d, {16'h0, exp_sum[15:0]})
			rd(DA);
			`CHK(d, {16'h0, exp_sum[31:16]})
		end
		wait_rdy();
		rd(DA);
		`CHK(d, {16'h0, SUM3[15:0]})
		rd(DA);
		`CHK(d, {16'h0, SUM3[31:16]})
		$display("test period done");
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// expected run is about 2500 cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			$display("unexpected %0t timeout", $time);
			close_out();
		end
	end
	initial
	begin
		{arst_n, smp_v, awv, wv, br, arv, rr, awa, ara, wd} <= '0;
		ws <= 4'hf;
		smp <= -8'sd127;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		smp_v <= 1'b1;
		t_reset();
		t_map();
		t_load();
		t_hold();
		t_per();
		close_out();
	end
endmodule
`default_nettype wire
